// *** design/ieeg_pkg.sv ***
// shared constants and carriers for the interrupt endpoint event gate
package ieeg_pkg;

    // register map, byte addresses on the 12-bit register port
    localparam logic [11:0] ADDR_EVENT_ENABLE = 12'h098;
    localparam logic [11:0] ADDR_PENDING = 12'h0a0;

    // enable register field positions
    localparam int BIT_ALWAYS_SEND = 31;
    localparam int BIT_OTP_WRITE_DONE = 28;
    localparam int BIT_TX_IDLE_START = 26;
    localparam int BIT_TX_IDLE_STOP = 25;
    localparam int BIT_RX_IDLE = 24;
    localparam int BIT_MAC_RESET_TIMEOUT = 23;
    localparam int BIT_RX_FIFO_OVERFLOW = 22;
    localparam int BIT_TRANSMIT_ERROR = 21;
    localparam int BIT_USB_STATUS = 20;
    localparam int BIT_TRANSMIT_DISABLED = 19;
    localparam int BIT_RECEIVE_DISABLED = 18;
    localparam int BIT_TRANSCEIVER = 17;
    localparam int BIT_DATA_PORT = 16;
    localparam int BIT_MAC_ERROR = 15;
    localparam int BIT_TX_FIFO_UNDERRUN = 14;
    localparam int BIT_TX_FIFO_OVERRUN = 13;
    localparam int BIT_FRAME_PENDING = 12;
    localparam int BIT_PIN_LSB = 0;
    localparam int PIN_COUNT = 12;
    localparam int USB_CHANGE_COUNT = 16;

    // reset value and writable bits (30, 29 and 27 are reserved, read zero)
    localparam logic [31:0] EVENT_ENABLE_RESET = 32'h0000_0000;
    localparam logic [31:0] EVENT_ENABLE_MASK = 32'h97ff_ffff;
    // bits that are event sources, the always-send bit is not one
    localparam logic [31:0] EVENT_SOURCE_MASK = 32'h17ff_ffff;

    // register port request
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ieeg_reg_req_s;

    // single-cycle event indications from the sources
    typedef struct packed {
        logic otp_write_done;
        logic energy_saving_tx_idle_start;
        logic energy_saving_tx_idle_stop;
        logic energy_saving_rx_idle;
        logic mac_reset_timeout;
        logic rx_fifo_overflow;
        logic transmit_error;
        logic transmit_disabled;
        logic receive_disabled;
        logic transceiver_event;
        logic data_port_event;
        logic mac_error;
        logic tx_fifo_underrun;
        logic tx_fifo_overrun;
        logic bulk_in_frame_pending;
        logic [11:0] pin_event;
    } ieeg_events_s;

    // answer to one poll of the interrupt endpoint
    typedef struct packed {
        logic send;
        logic no_data;
        logic [31:0] data;
    } ieeg_poll_ans_s;

endpackage

// *** design/ieeg_event_gate.sv ***
// interrupt endpoint event gate: enable register, pending capture, poll answer
//
// Operation
// - bit 31 set: packet every interval
// - bit 28 gates fuse write done
// - bit 26 gates tx idle start
// - bit 25 gates tx idle stop
// - bit 24 gates rx idle event
// - bit 23 gates mac reset timeout
// - bit 22 gates rx fifo overflow
// - bit 21 gates transmit error
// - bit 20 gates usb status change
// - bit 19 gates transmit disabled
// - bit 18 gates receive disabled
// - bit 17 gates transceiver interrupt
// - bit 16 gates data port event
// - bit 15 gates mac error
// - bit 14 gates tx fifo underrun
// - bit 13 gates tx fifo overrun
// - bit 12 gates bulk-in frame pending
// - bits 11:0 gate twelve pin events
// - any usb change bit raises status event
`timescale 1ns/1ps
`default_nettype none

module ieeg_event_gate (
    input wire logic mclk,
    input wire logic resetn,
    input wire ieeg_pkg::ieeg_reg_req_s reg_req,
    output logic [31:0] reg_rdata,
    input wire ieeg_pkg::ieeg_events_s events,
    input wire logic [15:0] usb_status_change,
    input wire logic poll_req,
    output ieeg_pkg::ieeg_poll_ans_s poll_ans,
    output logic any_pending
);

    // enable register and its next value
    logic [31:0] enable_q;
    logic [31:0] enable_d;

    // register port decode
    logic enable_wr_sel;
    logic enable_rd_sel;
    logic pending_rd_sel;

    // named views of the enable register fields
    logic always_send_interrupt_packet;
    logic otp_write_done_enable;
    logic energy_saving_tx_idle_start_enable;
    logic energy_saving_tx_idle_stop_enable;
    logic energy_saving_rx_idle_enable;
    logic mac_reset_timeout_enable;
    logic rx_fifo_overflow_enable;
    logic transmit_error_enable;
    logic usb_status_change_enable;
    logic transmit_disabled_enable;
    logic receive_disabled_enable;
    logic transceiver_event_enable;
    logic data_port_event_enable;
    logic mac_error_enable;
    logic tx_fifo_underrun_enable;
    logic tx_fifo_overrun_enable;
    logic bulk_in_frame_pending_enable;
    logic [11:0] pin_event_enables;

    // readback image rebuilt from the fields
    logic [31:0] enable_image;

    // source events and their gates, both at enable bit positions
    logic usb_status_event;
    logic [31:0] event_vec;
    logic [31:0] gate_vec;
    logic [31:0] hit;

    // pending flags and poll decode
    logic [31:0] pending_q;
    logic [31:0] pending_d;
    logic send_now;
    logic poll_take;
    logic poll_empty;

    // poll answer, one flop per field
    logic ans_send_q;
    logic ans_no_data_q;
    logic [31:0] ans_data_q;

    // summary flag and read data
    logic any_pending_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    // register port decode; the master never raises both strobes at once
    assign enable_wr_sel = reg_req.wr & (reg_req.addr == ieeg_pkg::ADDR_EVENT_ENABLE);
    assign enable_rd_sel = reg_req.rd & (reg_req.addr == ieeg_pkg::ADDR_EVENT_ENABLE);
    assign pending_rd_sel = reg_req.rd & (reg_req.addr == ieeg_pkg::ADDR_PENDING);

    // next enable value; reserved bits 30, 29 and 27 never take a write
    always_comb begin
        enable_d = enable_q;
        if (enable_wr_sel) begin
            enable_d = reg_req.wdata & ieeg_pkg::EVENT_ENABLE_MASK;
        end
    end

    // enable register; cleared at reset so no source reaches the host early
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            enable_q <= ieeg_pkg::EVENT_ENABLE_RESET;
        end else begin
            enable_q <= enable_d;
        end
    end

    // field views, named after what each enable lets through
    assign always_send_interrupt_packet = enable_q[ieeg_pkg::BIT_ALWAYS_SEND];
    assign otp_write_done_enable = enable_q[ieeg_pkg::BIT_OTP_WRITE_DONE];
    assign energy_saving_tx_idle_start_enable = enable_q[ieeg_pkg::BIT_TX_IDLE_START];
    assign energy_saving_tx_idle_stop_enable = enable_q[ieeg_pkg::BIT_TX_IDLE_STOP];
    assign energy_saving_rx_idle_enable = enable_q[ieeg_pkg::BIT_RX_IDLE];
    assign mac_reset_timeout_enable = enable_q[ieeg_pkg::BIT_MAC_RESET_TIMEOUT];
    assign rx_fifo_overflow_enable = enable_q[ieeg_pkg::BIT_RX_FIFO_OVERFLOW];
    assign transmit_error_enable = enable_q[ieeg_pkg::BIT_TRANSMIT_ERROR];
    assign usb_status_change_enable = enable_q[ieeg_pkg::BIT_USB_STATUS];
    assign transmit_disabled_enable = enable_q[ieeg_pkg::BIT_TRANSMIT_DISABLED];
    assign receive_disabled_enable = enable_q[ieeg_pkg::BIT_RECEIVE_DISABLED];
    assign transceiver_event_enable = enable_q[ieeg_pkg::BIT_TRANSCEIVER];
    assign data_port_event_enable = enable_q[ieeg_pkg::BIT_DATA_PORT];
    assign mac_error_enable = enable_q[ieeg_pkg::BIT_MAC_ERROR];
    assign tx_fifo_underrun_enable = enable_q[ieeg_pkg::BIT_TX_FIFO_UNDERRUN];
    assign tx_fifo_overrun_enable = enable_q[ieeg_pkg::BIT_TX_FIFO_OVERRUN];
    assign bulk_in_frame_pending_enable = enable_q[ieeg_pkg::BIT_FRAME_PENDING];
    assign pin_event_enables = enable_q[ieeg_pkg::BIT_PIN_LSB +: ieeg_pkg::PIN_COUNT];

    // readback image from the fields, so reserved bits read zero by construction
    always_comb begin
        enable_image = 32'h0000_0000;
        enable_image[ieeg_pkg::BIT_ALWAYS_SEND] = always_send_interrupt_packet;
        enable_image[ieeg_pkg::BIT_OTP_WRITE_DONE] = otp_write_done_enable;
        enable_image[ieeg_pkg::BIT_TX_IDLE_START] = energy_saving_tx_idle_start_enable;
        enable_image[ieeg_pkg::BIT_TX_IDLE_STOP] = energy_saving_tx_idle_stop_enable;
        enable_image[ieeg_pkg::BIT_RX_IDLE] = energy_saving_rx_idle_enable;
        enable_image[ieeg_pkg::BIT_MAC_RESET_TIMEOUT] = mac_reset_timeout_enable;
        enable_image[ieeg_pkg::BIT_RX_FIFO_OVERFLOW] = rx_fifo_overflow_enable;
        enable_image[ieeg_pkg::BIT_TRANSMIT_ERROR] = transmit_error_enable;
        enable_image[ieeg_pkg::BIT_USB_STATUS] = usb_status_change_enable;
        enable_image[ieeg_pkg::BIT_TRANSMIT_DISABLED] = transmit_disabled_enable;
        enable_image[ieeg_pkg::BIT_RECEIVE_DISABLED] = receive_disabled_enable;
        enable_image[ieeg_pkg::BIT_TRANSCEIVER] = transceiver_event_enable;
        enable_image[ieeg_pkg::BIT_DATA_PORT] = data_port_event_enable;
        enable_image[ieeg_pkg::BIT_MAC_ERROR] = mac_error_enable;
        enable_image[ieeg_pkg::BIT_TX_FIFO_UNDERRUN] = tx_fifo_underrun_enable;
        enable_image[ieeg_pkg::BIT_TX_FIFO_OVERRUN] = tx_fifo_overrun_enable;
        enable_image[ieeg_pkg::BIT_FRAME_PENDING] = bulk_in_frame_pending_enable;
        enable_image[ieeg_pkg::BIT_PIN_LSB +: ieeg_pkg::PIN_COUNT] = pin_event_enables;
    end

    // status change is the OR of every change bit, held while any stays set
    assign usb_status_event = |usb_status_change;

    // place each source at the bit position of its enable
    always_comb begin
        event_vec = 32'h0000_0000;
        event_vec[ieeg_pkg::BIT_OTP_WRITE_DONE] = events.otp_write_done;
        event_vec[ieeg_pkg::BIT_TX_IDLE_START] = events.energy_saving_tx_idle_start;
        event_vec[ieeg_pkg::BIT_TX_IDLE_STOP] = events.energy_saving_tx_idle_stop;
        event_vec[ieeg_pkg::BIT_RX_IDLE] = events.energy_saving_rx_idle;
        event_vec[ieeg_pkg::BIT_MAC_RESET_TIMEOUT] = events.mac_reset_timeout;
        event_vec[ieeg_pkg::BIT_RX_FIFO_OVERFLOW] = events.rx_fifo_overflow;
        event_vec[ieeg_pkg::BIT_TRANSMIT_ERROR] = events.transmit_error;
        event_vec[ieeg_pkg::BIT_USB_STATUS] = usb_status_event;
        event_vec[ieeg_pkg::BIT_TRANSMIT_DISABLED] = events.transmit_disabled;
        event_vec[ieeg_pkg::BIT_RECEIVE_DISABLED] = events.receive_disabled;
        event_vec[ieeg_pkg::BIT_TRANSCEIVER] = events.transceiver_event;
        event_vec[ieeg_pkg::BIT_DATA_PORT] = events.data_port_event;
        event_vec[ieeg_pkg::BIT_MAC_ERROR] = events.mac_error;
        event_vec[ieeg_pkg::BIT_TX_FIFO_UNDERRUN] = events.tx_fifo_underrun;
        event_vec[ieeg_pkg::BIT_TX_FIFO_OVERRUN] = events.tx_fifo_overrun;
        event_vec[ieeg_pkg::BIT_FRAME_PENDING] = events.bulk_in_frame_pending;
        event_vec[ieeg_pkg::BIT_PIN_LSB +: ieeg_pkg::PIN_COUNT] = events.pin_event;
    end

    // gate vector at the source positions; always-send and reserved
    // positions stay 0 so they can never hold a pending flag
    always_comb begin
        gate_vec = 32'h0000_0000;
        gate_vec[ieeg_pkg::BIT_OTP_WRITE_DONE] = otp_write_done_enable;
        gate_vec[ieeg_pkg::BIT_TX_IDLE_START] = energy_saving_tx_idle_start_enable;
        gate_vec[ieeg_pkg::BIT_TX_IDLE_STOP] = energy_saving_tx_idle_stop_enable;
        gate_vec[ieeg_pkg::BIT_RX_IDLE] = energy_saving_rx_idle_enable;
        gate_vec[ieeg_pkg::BIT_MAC_RESET_TIMEOUT] = mac_reset_timeout_enable;
        gate_vec[ieeg_pkg::BIT_RX_FIFO_OVERFLOW] = rx_fifo_overflow_enable;
        gate_vec[ieeg_pkg::BIT_TRANSMIT_ERROR] = transmit_error_enable;
        gate_vec[ieeg_pkg::BIT_USB_STATUS] = usb_status_change_enable;
        gate_vec[ieeg_pkg::BIT_TRANSMIT_DISABLED] = transmit_disabled_enable;
        gate_vec[ieeg_pkg::BIT_RECEIVE_DISABLED] = receive_disabled_enable;
        gate_vec[ieeg_pkg::BIT_TRANSCEIVER] = transceiver_event_enable;
        gate_vec[ieeg_pkg::BIT_DATA_PORT] = data_port_event_enable;
        gate_vec[ieeg_pkg::BIT_MAC_ERROR] = mac_error_enable;
        gate_vec[ieeg_pkg::BIT_TX_FIFO_UNDERRUN] = tx_fifo_underrun_enable;
        gate_vec[ieeg_pkg::BIT_TX_FIFO_OVERRUN] = tx_fifo_overrun_enable;
        gate_vec[ieeg_pkg::BIT_FRAME_PENDING] = bulk_in_frame_pending_enable;
        gate_vec[ieeg_pkg::BIT_PIN_LSB +: ieeg_pkg::PIN_COUNT] = pin_event_enables;
    end

    // a packet goes out when always-send is on or anything is pending
    assign send_now = always_send_interrupt_packet | (|pending_q);

    // a poll either takes the pending snapshot or gets a no-data answer
    assign poll_take = poll_req & send_now;
    assign poll_empty = poll_req & ~send_now;

    // per-source gate and sticky pending flag
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_src
            // an event only counts while its enable holds 1
            assign hit[gi] = event_vec[gi] & gate_vec[gi] & ieeg_pkg::EVENT_SOURCE_MASK[gi];
            // new hit beats the clear of a sent packet; disabling drops the flag
            assign pending_d[gi] = hit[gi]
                | (pending_q[gi] & gate_vec[gi] & ~poll_take);
        end
    endgenerate

    // pending flags; an event in the poll cycle waits for the next poll
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pending_q <= 32'h0000_0000;
        end else begin
            pending_q <= pending_d;
        end
    end

    // packet flag, one cycle after a poll that found something to send
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ans_send_q <= 1'b0;
        end else begin
            ans_send_q <= poll_take;
        end
    end

    // no-data flag, the answer while always-send is clear and nothing pends
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ans_no_data_q <= 1'b0;
        end else begin
            ans_no_data_q <= poll_empty;
        end
    end

    // pending snapshot; zero unless a packet goes out, so a no-data
    // answer never shows stale flags
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ans_data_q <= 32'h0000_0000;
        end else begin
            ans_data_q <= poll_take ? pending_q : 32'h0000_0000;
        end
    end

    // summary from the next state, so it lines up with the pending flags;
    // it falls when the host polls and drains them, or when their enables are cleared
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            any_pending_q <= 1'b0;
        end else begin
            any_pending_q <= |pending_d;
        end
    end

    // read data mux; unmapped addresses and idle cycles read as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (enable_rd_sel) begin
            rdata_d = enable_image;
        end else if (pending_rd_sel) begin
            rdata_d = pending_q;
        end
    end

    // read data register; stands only in the cycle after a read strobe
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // every output straight from a flop
    assign reg_rdata = rdata_q;
    assign poll_ans = '{send: ans_send_q, no_data: ans_no_data_q, data: ans_data_q};
    assign any_pending = any_pending_q;

endmodule

`default_nettype wire

// *** verification/ieeg_event_gate_monitor.sv ***
// assertion checker for the interrupt endpoint event gate
`timescale 1ns/1ps
`default_nettype none
module ieeg_event_gate_monitor (
    input wire logic mclk,
    input wire logic resetn,
    input wire ieeg_pkg::ieeg_reg_req_s reg_req,
    input wire logic [31:0] reg_rdata,
    input wire ieeg_pkg::ieeg_events_s events,
    input wire logic [15:0] usb_status_change,
    input wire logic poll_req,
    input wire ieeg_pkg::ieeg_poll_ans_s poll_ans,
    input wire logic any_pending
);
    logic [31:0] en_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // shadow enable, rebuilt from bus writes since the register is internal
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) en_q <= 32'h0000_0000;
        else if (reg_req.wr && reg_req.addr == ieeg_pkg::ADDR_EVENT_ENABLE)
            en_q <= reg_req.wdata & ieeg_pkg::EVENT_ENABLE_MASK;
    end
    property p_ans; poll_req |=> poll_ans.send ^ poll_ans.no_data; endproperty
    a_ans: assert property (p_ans) else $error("poll not answered once");
    property p_idle; !poll_req |=> !poll_ans.send && !poll_ans.no_data; endproperty
    a_idle: assert property (p_idle) else $error("answer without poll");
    property p_pend; poll_req && any_pending |=> poll_ans.send && poll_ans.data != 0; endproperty
    a_pend: assert property (p_pend) else $error("pending not sent");
    property p_all; poll_req && en_q[31] |=> poll_ans.send; endproperty
    a_all: assert property (p_all) else $error("always send missed");
    property p_off; poll_req && !en_q[31] && !any_pending |=> poll_ans.no_data; endproperty
    a_off: assert property (p_off) else $error("packet with nothing pending");
    property p_usb; (|usb_status_change) && en_q[20] && !reg_req.wr |=> any_pending; endproperty
    a_usb: assert property (p_usb) else $error("usb change lost");
    property p_gate; (en_q & ieeg_pkg::EVENT_SOURCE_MASK) == 0 |=> !any_pending; endproperty
    a_gate: assert property (p_gate) else $error("disabled event pending");
    property p_rd; reg_req.rd && reg_req.addr == 12'h098 |=> reg_rdata == $past(en_q); endproperty
    a_rd: assert property (p_rd) else $error("enable readback wrong");
endmodule
bind ieeg_event_gate ieeg_event_gate_monitor u_mon (.mclk(mclk), .resetn(resetn),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .events(events),
    .usb_status_change(usb_status_change), .poll_req(poll_req), .poll_ans(poll_ans),
    .any_pending(any_pending));
`default_nettype wire

// *** verification/ieeg_host_poller.sv ***
// host model polling the interrupt endpoint
`timescale 1ns/1ps
`default_nettype none
module ieeg_host_poller #(parameter int INTERVAL = 6) (
    input wire logic mclk,
    input wire logic resetn,
    output logic poll_req
);
    logic [7:0] cnt_q;
    // one poll pulse per interval, never faster than the host allows
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 8'h00;
            poll_req <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == 8'(INTERVAL - 1)) ? 8'h00 : cnt_q + 8'h01;
            poll_req <= (cnt_q == 8'(INTERVAL - 1));
        end
    end
endmodule
`default_nettype wire

// *** verification/ieeg_event_gate_tb.sv ***
// self-checking bench for the interrupt endpoint event gate
`timescale 1ns/1ps
`default_nettype none
module ieeg_event_gate_tb;
    logic mclk = 1'b0, resetn = 1'b0, poll_req, any_pending;
    ieeg_pkg::ieeg_reg_req_s reg_req = '0;
    ieeg_pkg::ieeg_events_s events = '0;
    ieeg_pkg::ieeg_poll_ans_s poll_ans;
    logic [31:0] reg_rdata;
    logic [15:0] usb = 16'h0000;
    int err_total = 0, n_compared = 0;
    always #2 mclk = ~mclk;
    ieeg_event_gate u_dut (.mclk(mclk), .resetn(resetn), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .events(events), .usb_status_change(usb),
        .poll_req(poll_req), .poll_ans(poll_ans), .any_pending(any_pending));
    ieeg_host_poller #(.INTERVAL(6)) u_host (.mclk(mclk), .resetn(resetn), .poll_req(poll_req));
    task automatic wrap_up;
        $display("compared %0d wrong %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge mclk) reg_req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk) reg_req.wr <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] exp);
        @(posedge mclk) reg_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge mclk) reg_req.rd <= 1'b0;
        #1 chk("reg_rdata", exp, reg_rdata);
    endtask
    // waits for the next poll answer, bounded so a dead endpoint ends the run
    task automatic ans(logic snd, logic [31:0] exp);
        int i = 0;
        do begin
            @(posedge mclk) #1;
            i++;
        end while (poll_ans.send !== 1'b1 && poll_ans.no_data !== 1'b1 && i < 20);
        if (poll_ans.send !== 1'b1 && poll_ans.no_data !== 1'b1) begin
            $display("wrong value poll answer expected 1 seen 0");
            err_total++;
            wrap_up();
        end else begin
            chk("send", {31'h0, snd}, {31'h0, poll_ans.send});
            chk("data", exp, poll_ans.data);
        end
    endtask
    // one-cycle event; the answer scan then starts past the latching edge
    task automatic fire(int b);
        @(posedge mclk);
        if (b == 20) usb <= 16'h8000;
        else events <= ieeg_pkg::ieeg_events_s'(27'h1 << (b - (b > 20) - (b > 27)));
        @(posedge mclk);
        events <= '0;
        usb <= 16'h0000;
    endtask
    // source alone enabled is reported, then blocked with all others enabled
    task automatic gate(int b);
        wr(ieeg_pkg::ADDR_EVENT_ENABLE, 32'h1 << b);
        fire(b);
        #1 chk("any_pending", 32'h1, {31'h0, any_pending});
        ans(1'b1, 32'h1 << b);
        wr(ieeg_pkg::ADDR_EVENT_ENABLE, ieeg_pkg::EVENT_SOURCE_MASK & ~(32'h1 << b));
        fire(b);
        #1 chk("any_pending", 32'h0, {31'h0, any_pending});
        rd(ieeg_pkg::ADDR_PENDING, 32'h0);
        ans(1'b0, 32'h0);
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        rd(ieeg_pkg::ADDR_EVENT_ENABLE, 32'h0000_0000);
        ans(1'b0, 32'h0);
        wr(ieeg_pkg::ADDR_EVENT_ENABLE, 32'hffff_ffff);
        rd(ieeg_pkg::ADDR_EVENT_ENABLE, 32'h97ff_ffff);
        ans(1'b1, 32'h0);
        rd(12'h0ff, 32'h0);
        for (int b = 0; b < 20; b++) gate(b);
        for (int b = 20; b < 27; b++) gate(b);
        gate(28);
        wrap_up();
    end
endmodule
`default_nettype wire
